// >>> design/tfc_regs.svh
// register offsets, field positions and constants of the free-running timer counter
`ifndef TFC_REGS_SVH
`define TFC_REGS_SVH

`define TFC_OFF_COUNT_HIGH     12'h000
`define TFC_OFF_COUNT_LOW      12'h004
`define TFC_OFF_ALT_HIGH       12'h008
`define TFC_OFF_ALT_LOW        12'h00c
`define TFC_OFF_STATUS         12'h010
`define TFC_OFF_CONTROL_ONE    12'h014
`define TFC_OFF_CONTROL_TWO    12'h018
`define TFC_OFF_CONDITION      12'h01c

`define TFC_RELOAD_VALUE       16'hfffc
`define TFC_WRAP_VALUE         16'hffff

`define TFC_BIT_OVERFLOW       5
`define TFC_BIT_IRQ_ENABLE     5
`define TFC_BIT_EDGE_SELECT    0
`define TFC_BIT_CLK_SEL_LO     2
`define TFC_BIT_CLK_SEL_HI     3
`define TFC_BIT_IRQ_MASK       3

`define TFC_CLK_DIV2           2'b00
`define TFC_CLK_DIV4           2'b01
`define TFC_CLK_DIV8           2'b10
`define TFC_CLK_EXT            2'b11

`define TFC_CR1_RESET          8'h00
`define TFC_CR2_RESET          8'h00
`define TFC_CC_RESET           8'h08
`define TFC_PRESC_RESET        3'h0

`endif

// >>> design/tfc_pkg.sv
// types shared by the free-running timer counter
package tfc_pkg;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tfc_apb_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } tfc_apb_rsp_s;

  typedef enum logic [1:0] {
    TFC_SEQ_IDLE    = 2'b00,
    TFC_SEQ_LATCHED = 2'b01
  } tfc_seq_e;

  typedef enum logic [1:0] {
    TFC_CLR_IDLE  = 2'b00,
    TFC_CLR_ARMED = 2'b01
  } tfc_clr_e;

endpackage

// >>> design/tfc_counter.sv
// counter core of the 16-bit timer with APB register access
`timescale 1ns/100ps
`include "tfc_regs.svh"

// Functional notes
// - 16-bit up-counter read as two bytes
// - main and alternate views show same count
// - prescaled clock divides by 2, 4, 8
// - clock select 11 picks external clock
// - edge select picks rising or falling
// - external updates align to clock falling edge
// - low byte write reloads fffc
// - reset start value is fffc
// - high read latches low byte
// - lone low read returns live byte
// - wrap ffff to 0000 sets overflow
// - overflow interrupt when enabled and unmasked
// - status read then low access clears flag
// - alternate low access never clears flag
// - wait mode changes nothing
// - halt stops counter, resumes held count
// - unbonded external pin reads as one
// - instances share nothing, count in step on prescaled clocks
module tfc_counter #(
  parameter int          WIDTH  = 16,
  parameter logic        PIN_BONDED = 1'b1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output      logic [31:0]  prdata,
  output      logic         pready,
  output      logic         pslverr,
  // low-power and pins
  input  wire logic         halt_mode,
  input  wire logic         ext_clock_pin,
  // outputs to the rest of the timer
  output      logic [15:0]  count_value,
  output      logic         timer_irq
);

  // bus request bundled as the package carrier
  tfc_pkg::tfc_apb_req_s req;
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // decode helper used for every register hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic [15:0]             count;
  logic [7:0]              latched_low;
  tfc_pkg::tfc_seq_e       seq_state;
  tfc_pkg::tfc_clr_e       clr_state;
  logic                    overflow_flag;
  logic [7:0]              timer_control_one;
  logic [7:0]              timer_control_two;
  logic [7:0]              condition_code_reg;
  logic [2:0]              presc;
  logic                    ext_sync1;
  logic                    ext_sync2;
  logic                    ext_fall_sample;
  logic                    ext_prev;
  logic [31:0]             rdata_q;

  wire logic access    = req.sel & req.enable;
  wire logic rd        = access & ~req.write;
  wire logic wr        = access & req.write;
  wire logic hit_ch    = hit(req.addr, `TFC_OFF_COUNT_HIGH);
  wire logic hit_cl    = hit(req.addr, `TFC_OFF_COUNT_LOW);
  wire logic hit_ah    = hit(req.addr, `TFC_OFF_ALT_HIGH);
  wire logic hit_al    = hit(req.addr, `TFC_OFF_ALT_LOW);
  wire logic hit_sr    = hit(req.addr, `TFC_OFF_STATUS);
  wire logic hit_c1    = hit(req.addr, `TFC_OFF_CONTROL_ONE);
  wire logic hit_c2    = hit(req.addr, `TFC_OFF_CONTROL_TWO);
  wire logic hit_cc    = hit(req.addr, `TFC_OFF_CONDITION);
  wire logic mapped    = hit_ch | hit_cl | hit_ah | hit_al | hit_sr | hit_c1 | hit_c2 | hit_cc;

  wire logic [1:0] clock_select          = timer_control_two[`TFC_BIT_CLK_SEL_HI:`TFC_BIT_CLK_SEL_LO];
  wire logic       ext_clock_edge_select = timer_control_two[`TFC_BIT_EDGE_SELECT];
  wire logic       overflow_irq_enable   = timer_control_one[`TFC_BIT_IRQ_ENABLE];
  wire logic       irq_mask              = condition_code_reg[`TFC_BIT_IRQ_MASK];

  // control writes need byte lane 0, where every field lives
  wire logic wr_c1 = wr & hit_c1 & pstrb[0];
  wire logic wr_c2 = wr & hit_c2 & pstrb[0];
  wire logic wr_cc = wr & hit_cc & pstrb[0];

  wire logic ext_pin_level = PIN_BONDED ? ext_clock_pin : 1'b1;

  wire logic presc_tick =
    (clock_select == `TFC_CLK_DIV2) ? (presc[0] == 1'b1) :
    (clock_select == `TFC_CLK_DIV4) ? (presc[1:0] == 2'b11) :
    (clock_select == `TFC_CLK_DIV8) ? (presc == 3'h7) : 1'b0;

  // edge select, one tick per edge
  wire logic ext_edge =
    ext_clock_edge_select ? (ext_fall_sample & ~ext_prev) : (~ext_fall_sample & ext_prev);

  // external mode picks the pin edge
  wire logic count_tick = (clock_select == `TFC_CLK_EXT) ? ext_edge : presc_tick;

  wire logic reload = wr & (hit_cl | hit_al);

  wire logic wrap = count_tick & ~halt_mode & ~reload & (count == `TFC_WRAP_VALUE);

  // high read opens sequence, low read closes it
  wire logic high_read = rd & (hit_ch | hit_ah);
  wire logic low_read  = rd & (hit_cl | hit_al);

  // clearing access on main low byte only; alternate excluded
  wire logic main_low_access = access & hit_cl;
  wire logic flag_clear      = (clr_state == tfc_pkg::TFC_CLR_ARMED) & main_low_access;

  wire logic [7:0] low_view = (seq_state == tfc_pkg::TFC_SEQ_LATCHED) ? latched_low : count[7:0];

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    // both views return the same count
    if (hit_ch | hit_ah)
    begin
      next_rdata[7:0] = count[15:8];
    end
    else if (hit_cl | hit_al)
    begin
      next_rdata[7:0] = low_view;
    end
    else if (hit_sr)
    begin
      next_rdata[`TFC_BIT_OVERFLOW] = overflow_flag;
    end
    else if (hit_c1)
    begin
      next_rdata[7:0] = timer_control_one;
    end
    else if (hit_c2)
    begin
      next_rdata[7:0] = timer_control_two;
    end
    else if (hit_cc)
    begin
      next_rdata[7:0] = condition_code_reg;
    end
  end

  // zero-wait slave; read data comes straight from a register-free mux of flops
  assign pready      = 1'b1;
  assign pslverr     = access & ~mapped;
  assign prdata      = rd ? next_rdata : rdata_q;
  assign count_value = count;

  // interrupt stays pending while flag holds
  assign timer_irq = overflow_flag & overflow_irq_enable & ~irq_mask;

  // external pin sampled on the falling clock edge after synchronising
  // sync flops reset to one, the level an unbonded pin shows
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync1 <= 1'b1;
      ext_sync2 <= 1'b1;
    end
    else
    begin
      ext_sync1 <= ext_pin_level;
      ext_sync2 <= ext_sync1;
    end
  end

  // half-cycle stage lands the edge on a falling clock
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_fall_sample <= 1'b1;
    end
    else
    begin
      ext_fall_sample <= ext_sync2;
    end
  end

  // previous sample for the edge detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_prev <= 1'b1;
    end
    else
    begin
      ext_prev <= ext_fall_sample;
    end
  end

  // prescaler frozen in halt; wait has no input here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc <= `TFC_PRESC_RESET;
    end
    else if (!halt_mode)
    begin
      presc <= presc + 3'h1;
    end
  end

  // counter, reset and reload to fffc
  // reload beats counting in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= `TFC_RELOAD_VALUE;
    end
    else if (reload)
    begin
      count <= `TFC_RELOAD_VALUE;
    end
    else if (count_tick && !halt_mode)
    begin
      count <= count + 16'h0001;
    end
  end

  // latch held across repeated high reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_state   <= tfc_pkg::TFC_SEQ_IDLE;
      latched_low <= 8'h00;
    end
    else
    begin
      case (seq_state)
        tfc_pkg::TFC_SEQ_IDLE:
        begin
          if (high_read)
          begin
            seq_state   <= tfc_pkg::TFC_SEQ_LATCHED;
            latched_low <= count[7:0];
          end
        end
        tfc_pkg::TFC_SEQ_LATCHED:
        begin
          if (low_read)
          begin
            seq_state <= tfc_pkg::TFC_SEQ_IDLE;
          end
        end
        default:
        begin
          seq_state <= tfc_pkg::TFC_SEQ_IDLE;
        end
      endcase
    end
  end

  // set by a wrap; a wrap in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_flag <= 1'b0;
    end
    else if (wrap)
    begin
      overflow_flag <= 1'b1;
    end
    else if (flag_clear)
    begin
      overflow_flag <= 1'b0;
    end
  end

  // arm on status read with flag set, disarm on main low access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_state <= tfc_pkg::TFC_CLR_IDLE;
    end
    else
    begin
      case (clr_state)
        tfc_pkg::TFC_CLR_IDLE:
        begin
          if (rd && hit_sr && overflow_flag)
          begin
            clr_state <= tfc_pkg::TFC_CLR_ARMED;
          end
        end
        tfc_pkg::TFC_CLR_ARMED:
        begin
          if (main_low_access)
          begin
            clr_state <= tfc_pkg::TFC_CLR_IDLE;
          end
        end
        default:
        begin
          clr_state <= tfc_pkg::TFC_CLR_IDLE;
        end
      endcase
    end
  end

  // control registers; byte lane 0 carries all fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_one <= `TFC_CR1_RESET;
    end
    else if (wr_c1)
    begin
      timer_control_one <= req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_two <= `TFC_CR2_RESET;
    end
    else if (wr_c2)
    begin
      timer_control_two <= req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      condition_code_reg <= `TFC_CC_RESET;
    end
    else if (wr_cc)
    begin
      condition_code_reg <= req.wdata[7:0];
    end
  end

  // last read value, shown on prdata between reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd)
    begin
      rdata_q <= next_rdata;
    end
  end

endmodule

// >>> tb/tfc_counter_sva.sv
// assertions on the timer counter ports
`timescale 1ns/100ps
`include "tfc_regs.svh"
module tfc_counter_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // timer
  input wire logic        halt_mode,
  input wire logic [15:0] count_value,
  input wire logic        timer_irq
);
  wire acc    = psel & penable;
  wire wr_low = acc & pwrite & (paddr == `TFC_OFF_COUNT_LOW || paddr == `TFC_OFF_ALT_LOW);
  wire rd_hi  = acc & !pwrite & (paddr == `TFC_OFF_COUNT_HIGH || paddr == `TFC_OFF_ALT_HIGH);
  wire alt_lo = acc & (paddr == `TFC_OFF_ALT_LOW);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_start: assert property ($rose(presetn) |-> count_value == `TFC_RELOAD_VALUE)
    else $error("count not at reload value after reset");
  a_reload_write: assert property (wr_low |=> count_value == `TFC_RELOAD_VALUE)
    else $error("low byte write did not reload");
  a_count_step: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 16'h0001 || count_value == `TFC_RELOAD_VALUE)
    else $error("count moved by other than one");
  // fastest rate is one step every two clocks
  a_count_gap: assert property ($changed(count_value) && count_value != `TFC_RELOAD_VALUE && !wr_low
    |=> $stable(count_value))
    else $error("count stepped on two clocks in a row");
  a_halt_freeze: assert property (halt_mode && !wr_low |=> $stable(count_value))
    else $error("count moved while halted");
  a_high_view: assert property (rd_hi |-> prdata[7:0] == count_value[15:8])
    else $error("high byte read differs from count");
  a_irq_hold: assert property (timer_irq && !acc |=> timer_irq)
    else $error("interrupt dropped without an access");
  a_alt_keeps: assert property (timer_irq && alt_lo |=> timer_irq)
    else $error("alternate low access cleared overflow");

  c_irq_rise: cover property ($rose(timer_irq));
  c_reload: cover property (wr_low);
  c_halt_exit: cover property (halt_mode ##1 !halt_mode);
endmodule

// >>> tb/tfc_ext_clock_src.sv
// external clock source feeding the timer's clock pin
`timescale 1ns/100ps
module tfc_ext_clock_src (
  // clock and control
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  // pin
  output      logic pin
);
  logic [3:0] cnt;

  // edges eight clocks apart, twice the minimum
  // pin holds its level while stopped, so stopping makes no runt edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
    end
    else if (run)
    begin
      cnt <= cnt + 4'h1;
    end
  end
  assign pin = cnt[3];
endmodule

// >>> tb/tfc_counter_tb.sv
// self-checking bench for the timer counter core
`timescale 1ns/100ps
`include "tfc_regs.svh"
module tfc_counter_tb;
  logic        pclk, presetn, psel, penable, pwrite, halt_mode, run, ext_pin;
  logic        pready, pslverr, timer_irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] count_value;
  logic [15:0] count_b;
  logic [7:0]  hi;
  int          bad_count, num_checks;

  always #50 pclk = ~pclk;

  tfc_ext_clock_src i_tfc_ext_clock_src (.pclk(pclk), .presetn(presetn), .run(run), .pin(ext_pin));
  tfc_counter i_tfc_counter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_mode(halt_mode), .ext_clock_pin(ext_pin), .count_value(count_value), .timer_irq(timer_irq));
  // second timer with its clock pin not bonded, on the same bus
  tfc_counter #(.PIN_BONDED(1'b0)) i_tfc_counter_unbonded (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(), .pready(),
    .pslverr(), .halt_mode(halt_mode), .ext_clock_pin(ext_pin), .count_value(count_b), .timer_irq());

  task summarize;
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] lo, input logic [15:0] up, input logic [15:0] s);
    num_checks++;
    if ((s >= lo && s <= up) !== 1'b1)
    begin
      bad_count++;
      $display("Error %s exp %h..%h got %h", n, lo, up, s);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", {8'h0, e}, {8'h0, e}, {8'h0, rdat[7:0]});
  endtask

  task rdcnt(input logic [15:0] lo, input logic [15:0] up);
    apb(1'b0, `TFC_OFF_ALT_HIGH, 32'h0);
    hi = rdat[7:0];
    apb(1'b0, `TFC_OFF_ALT_LOW, 32'h0);
    chk("count", lo, up, {hi, rdat[7:0]});
  endtask

  // looked at one edge after the access that moved it
  task irq(input logic e);
    @(posedge pclk);
    chk("timer_irq", {15'h0, e}, {15'h0, e}, {15'h0, timer_irq});
  endtask

  // halt stops the prescaler too, so a run window gives a known step count
  task go(input int n);
    halt_mode <= 1'b0;
    repeat (n) @(posedge pclk);
    halt_mode <= 1'b1;
  endtask

  initial
  begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    halt_mode  = 1'b1;
    run        = 1'b0;
    bad_count  = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TFC_OFF_COUNT_HIGH, 8'hff);
    go(6);
    rd(`TFC_OFF_ALT_HIGH, 8'hff);
    rd(`TFC_OFF_COUNT_LOW, 8'hfc);
    rd(`TFC_OFF_ALT_LOW, 8'hff);
    apb(1'b1, `TFC_OFF_ALT_LOW, 32'h0);
    rd(`TFC_OFF_ALT_LOW, 8'hfc);
    apb(1'b1, `TFC_OFF_CONTROL_ONE, 32'h20);
    go(20);
    irq(1'b0);
    apb(1'b1, `TFC_OFF_CONDITION, 32'h0);
    irq(1'b1);
    rd(`TFC_OFF_STATUS, 8'h20);
    apb(1'b0, `TFC_OFF_ALT_LOW, 32'h0);
    rd(`TFC_OFF_STATUS, 8'h20);
    apb(1'b0, `TFC_OFF_COUNT_LOW, 32'h0);
    rd(`TFC_OFF_STATUS, 8'h00);
    irq(1'b0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `TFC_OFF_CONTROL_TWO, 32'(i << 2));
      apb(1'b1, `TFC_OFF_COUNT_LOW, 32'h0);
      go(16 << i);
      rdcnt(16'h0003, 16'h0005);
      chk("count_b", 16'h0003, 16'h0005, count_b);
    end
    // first run from low: 5 rises, 4 falls; second from high: 3 rises, 4 falls
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, `TFC_OFF_CONTROL_TWO, 32'h0c | 32'(e));
      apb(1'b1, `TFC_OFF_COUNT_LOW, 32'h0);
      halt_mode <= 1'b0;
      run       <= 1'b1;
      repeat (72 - 16 * e) @(posedge pclk);
      run <= 1'b0;
      repeat (8) @(posedge pclk);
      halt_mode <= 1'b1;
      rdcnt(e ? 16'hffff : 16'h0000, e ? 16'hffff : 16'h0000);
      chk("count_b", 16'hfffc, 16'hfffc, count_b);
    end
    rd(12'h020, 8'h00);
    chk("pslverr", 16'h1, 16'h1, {15'h0, rerr});
    summarize();
  end

  initial
  begin
    repeat (4000) @(posedge pclk);
    bad_count++;
    summarize();
  end
endmodule

bind tfc_counter tfc_counter_sva i_tfc_counter_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .halt_mode(halt_mode),
  .count_value(count_value), .timer_irq(timer_irq));
